// ==== rtl/twu_pkg.sv ====
package twu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special register bus
  localparam int TWU_SFR_AW = 8;  // Register address width
  localparam int TWU_SFR_DW = 8;  // Register data width

  // Key register and its two key values
  localparam logic [7:0] TWU_KEY_ADDR = 8'hc7;
  localparam logic [7:0] TWU_KEY_RESET = 8'h00;
  localparam logic [7:0] TWU_KEY_FIRST = 8'haa;
  localparam logic [7:0] TWU_KEY_SECOND = 8'h55;

  // Protected registers and the unprotected interrupt enable register
  localparam logic [7:0] TWU_WDOG_ADDR = 8'hd8;
  localparam logic [7:0] TWU_BOD_ADDR = 8'ha3;
  localparam logic [7:0] TWU_IE_ADDR = 8'ha8;
  localparam logic [7:0] TWU_WDOG_RESET = 8'h00;
  localparam logic [7:0] TWU_BOD_RESET = 8'h00;
  localparam logic [7:0] TWU_IE_RESET = 8'h00;
  localparam int TWU_IE_GLOBAL_BIT = 7;  // Global interrupt enable position
  localparam int TWU_IRQ_SOURCES = 7;    // Individual enables in bits 6:0

  // Cycle counts of the unlock sequence
  localparam int TWU_WAIT_CYCLES = 3;    // Second key must follow within
  localparam int TWU_WINDOW_CYCLES = 4;  // Protected write window length
  localparam int TWU_CNT_W = 3;          // Width of both counters

  ////////////////////////////////////////////////////////////////////////////
  // Controller register map on Avalon-MM (byte addresses)
  localparam int TWU_AV_AW = 4;
  localparam logic [3:0] TWU_AV_WRITE_OFS = 4'h0;  // Plain register write
  localparam logic [3:0] TWU_AV_PROT_OFS = 4'h4;   // Unlock then write
  localparam logic [3:0] TWU_AV_READ_OFS = 4'h8;   // Register read
  localparam logic [3:0] TWU_AV_STAT_OFS = 4'hc;   // Busy and read data
  localparam int TWU_AV_BUSY_BIT = 8;

endpackage

// ==== rtl/twu_sfr_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Special register bus between the processor side and the unlock gate
interface twu_sfr_if;
  import twu_pkg::*;
  logic wr;                        // One-cycle write strobe
  logic rd;                        // One-cycle read strobe
  logic [TWU_SFR_AW-1:0] addr;     // Register address
  logic [TWU_SFR_DW-1:0] wdata;    // Write data
  logic [TWU_SFR_DW-1:0] rdata;    // Read data, valid the cycle after rd

  modport core (output wr, output rd, output addr, output wdata, input rdata);
  modport gate (input wr, input rd, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== rtl/twu_gate.sv ====
// Unlock gate: key sequence, write window and protected registers on the register bus.
`timescale 1ns/100ps
`default_nettype none
module twu_gate
  import twu_pkg::*;
#(
  parameter int WAIT_CYCLES = TWU_WAIT_CYCLES,
  parameter int WINDOW_CYCLES = TWU_WINDOW_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  twu_sfr_if.gate sfr,
  input wire logic [TWU_IRQ_SOURCES-1:0] i_irq_flags,
  output logic o_irq_request,
  output logic [7:0] o_watchdog_ctrl,
  output logic [7:0] o_brownout_ctrl,
  output logic o_window_open,
  output logic o_write_dropped
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Both counts must fit the shared counter width and be at least one
  if (WAIT_CYCLES < 1 || WAIT_CYCLES > (2 ** TWU_CNT_W) - 1) begin : g_bad_wait
    $error("WAIT_CYCLES out of range");
  end
  if (WINDOW_CYCLES < 1 || WINDOW_CYCLES > (2 ** TWU_CNT_W) - 1) begin : g_bad_win
    $error("WINDOW_CYCLES out of range");
  end

  localparam logic [TWU_CNT_W-1:0] WAIT_LOAD = TWU_CNT_W'(WAIT_CYCLES);
  localparam logic [TWU_CNT_W-1:0] WIN_LOAD = TWU_CNT_W'(WINDOW_CYCLES);
  localparam logic [TWU_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [TWU_CNT_W-1:0] CNT_ONE = TWU_CNT_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] key_q;  // Last value written to the key register
  logic [7:0] key_d;
  logic [TWU_CNT_W-1:0] wait_q;  // Cycles left to see the second key
  logic [TWU_CNT_W-1:0] wait_d;
  logic [TWU_CNT_W-1:0] win_q;  // Cycles left in the write window
  logic [TWU_CNT_W-1:0] win_d;
  logic [7:0] wdog_q;  // Protected watchdog control
  logic [7:0] wdog_d;
  logic [7:0] bod_q;  // Protected brown-out control
  logic [7:0] bod_d;
  logic [7:0] ie_q;  // Interrupt enables, not protected
  logic [7:0] ie_d;
  logic [7:0] rdata_q;  // Registered read data
  logic [7:0] rdata_d;
  logic drop_q;  // Pulse: a protected write was discarded
  logic drop_d;
  logic irq_q;  // Registered interrupt request
  logic irq_d;

  // Decoded strobes of the current cycle
  logic key_wr;
  logic wdog_wr;
  logic bod_wr;
  logic window_active;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Key sequence, window, protected registers, reads and interrupt gate
  always_comb begin
    key_d = key_q;
    wait_d = wait_q;
    win_d = win_q;
    wdog_d = wdog_q;
    bod_d = bod_q;
    ie_d = ie_q;
    rdata_d = rdata_q;
    drop_d = 1'b0;

    key_wr = sfr.wr && (sfr.addr == TWU_KEY_ADDR);
    wdog_wr = sfr.wr && (sfr.addr == TWU_WDOG_ADDR);
    bod_wr = sfr.wr && (sfr.addr == TWU_BOD_ADDR);
    // Window counts down from its load value, so it is open for exactly
    // the load value of cycles following the second key write
    window_active = (win_q != CNT_ZERO);

    // Both counters run down on their own
    if (wait_q != CNT_ZERO) begin
      wait_d = wait_q - CNT_ONE;
    end
    if (win_q != CNT_ZERO) begin
      win_d = win_q - CNT_ONE;
    end

    // Key register: stored value also tells whether a first key is pending
    if (key_wr) begin
      key_d = sfr.wdata;
      if (sfr.wdata == TWU_KEY_FIRST) begin
        // A first key, even mid-sequence, restarts the wait
        wait_d = WAIT_LOAD;
      end else if (sfr.wdata == TWU_KEY_SECOND && key_q == TWU_KEY_FIRST
                   && wait_q != CNT_ZERO) begin
        // Second key in time opens the window
        win_d = WIN_LOAD;
        wait_d = CNT_ZERO;
      end else begin
        // Late second key or any other value abandons the sequence
        wait_d = CNT_ZERO;
      end
    end

    // Protected writes land only inside the window; window stays open
    // after one write so a second one may still land while time remains
    if (wdog_wr) begin
      if (window_active) begin
        wdog_d = sfr.wdata;
      end else begin
        drop_d = 1'b1;
      end
    end
    if (bod_wr) begin
      if (window_active) begin
        bod_d = sfr.wdata;
      end else begin
        drop_d = 1'b1;
      end
    end

    // Interrupt enables are never protected
    if (sfr.wr && sfr.addr == TWU_IE_ADDR) begin
      ie_d = sfr.wdata;
    end

    // Reads are never gated; the key register reads as zero
    if (sfr.rd) begin
      case (sfr.addr)
        TWU_WDOG_ADDR: begin
          rdata_d = wdog_q;
        end
        TWU_BOD_ADDR: begin
          rdata_d = bod_q;
        end
        TWU_IE_ADDR: begin
          rdata_d = ie_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end

    // Flags held by their sources stay pending while the global bit is low
    irq_d = ie_q[TWU_IE_GLOBAL_BIT]
            && ((i_irq_flags & ie_q[TWU_IRQ_SOURCES-1:0]) != '0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // All state frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key_q <= TWU_KEY_RESET;
      wait_q <= CNT_ZERO;
      win_q <= CNT_ZERO;
      wdog_q <= TWU_WDOG_RESET;
      bod_q <= TWU_BOD_RESET;
      ie_q <= TWU_IE_RESET;
      rdata_q <= 8'h00;
      drop_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (i_ce) begin
      key_q <= key_d;
      wait_q <= wait_d;
      win_q <= win_d;
      wdog_q <= wdog_d;
      bod_q <= bod_d;
      ie_q <= ie_d;
      rdata_q <= rdata_d;
      drop_q <= drop_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sfr.rdata = rdata_q;
  assign o_watchdog_ctrl = wdog_q;
  assign o_brownout_ctrl = bod_q;
  assign o_window_open = window_active;
  assign o_write_dropped = drop_q;
  assign o_irq_request = irq_q;

endmodule
`default_nettype wire

// ==== rtl/twu_core.sv ====
`timescale 1ns/100ps
`default_nettype none
// Processor-side end: takes orders over Avalon-MM and drives the register bus
module twu_core
  import twu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [TWU_AV_AW-1:0] i_av_address,
  input wire logic i_av_read,
  input wire logic i_av_write,
  input wire logic [31:0] i_av_writedata,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  twu_sfr_if.core sfr
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,  // Ready for a command
    ST_KEY2 = 5'b00010,  // Second key goes out next
    ST_PROT = 5'b00100,  // Protected write goes out next
    ST_RWAIT = 5'b01000,  // Read strobe on the bus
    ST_CAPT = 5'b10000  // Read data stands on the bus
  } twu_state_type;

  twu_state_type state_q;
  twu_state_type state_d;
  logic wr_q;  // Bus write strobe
  logic wr_d;
  logic rd_q;  // Bus read strobe
  logic rd_d;
  logic [7:0] addr_q;  // Bus address
  logic [7:0] addr_d;
  logic [7:0] wdata_q;  // Bus write data
  logic [7:0] wdata_d;
  logic [15:0] cmd_q;  // Held target address and data
  logic [15:0] cmd_d;
  logic [7:0] last_q;  // Last register value read
  logic [7:0] last_d;
  logic rvalid_q;  // Avalon read answered this cycle
  logic rvalid_d;
  logic [31:0] rdout_q;  // Avalon read data
  logic [31:0] rdout_d;
  logic cmd_hit;  // Avalon write to a command offset
  logic busy;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Commands wait while busy; reads answer after one wait cycle
  always_comb begin
    state_d = state_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    cmd_d = cmd_q;
    last_d = last_q;
    rvalid_d = 1'b0;
    rdout_d = rdout_q;
    busy = (state_q != ST_IDLE);
    cmd_hit = i_av_write && (i_av_address == TWU_AV_WRITE_OFS
              || i_av_address == TWU_AV_PROT_OFS || i_av_address == TWU_AV_READ_OFS);

    case (state_q)
      ST_IDLE: begin
        if (i_av_write && i_av_address == TWU_AV_WRITE_OFS) begin
          wr_d = 1'b1;
          addr_d = i_av_writedata[15:8];
          wdata_d = i_av_writedata[7:0];
        end else if (i_av_write && i_av_address == TWU_AV_PROT_OFS) begin
          // Each protected write gets a fresh unlock
          cmd_d = i_av_writedata[15:0];
          wr_d = 1'b1;
          addr_d = TWU_KEY_ADDR;
          wdata_d = TWU_KEY_FIRST;
          state_d = ST_KEY2;
        end else if (i_av_write && i_av_address == TWU_AV_READ_OFS) begin
          rd_d = 1'b1;
          addr_d = i_av_writedata[15:8];
          state_d = ST_RWAIT;
        end
      end
      ST_KEY2: begin
        // Back to back, nothing can slip between the three writes
        wr_d = 1'b1;
        wdata_d = TWU_KEY_SECOND;
        state_d = ST_PROT;
      end
      ST_PROT: begin
        wr_d = 1'b1;
        addr_d = cmd_q[15:8];
        wdata_d = cmd_q[7:0];
        state_d = ST_IDLE;
      end
      ST_RWAIT: begin
        state_d = ST_CAPT;
      end
      ST_CAPT: begin
        last_d = sfr.rdata;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase

    // Register reads: unmapped offsets read zero
    if (i_av_read && !rvalid_q) begin
      rvalid_d = 1'b1;
      rdout_d = 32'h0000_0000;
      if (i_av_address == TWU_AV_STAT_OFS) begin
        rdout_d[TWU_AV_BUSY_BIT] = busy;
        rdout_d[7:0] = last_q;
      end
    end
  end

  // Stall while frozen, while busy on commands, and for the read answer
  assign o_av_waitrequest = !i_ce || (cmd_hit && busy) || (i_av_read && !rvalid_q);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      cmd_q <= 16'h0000;
      last_q <= 8'h00;
      rvalid_q <= 1'b0;
      rdout_q <= 32'h0000_0000;
    end else if (i_ce) begin
      state_q <= state_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      cmd_q <= cmd_d;
      last_q <= last_d;
      rvalid_q <= rvalid_d;
      rdout_q <= rdout_d;
    end
  end

  assign sfr.wr = wr_q;
  assign sfr.rd = rd_q;
  assign sfr.addr = addr_q;
  assign sfr.wdata = wdata_q;
  assign o_av_readdata = rdout_q;

endmodule
`default_nettype wire

// ==== test/twu_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Watches the register bus between the two ends and the gate outputs
module twu_asserts
  import twu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic wr,
  input wire logic rd,
  input wire logic [TWU_SFR_AW-1:0] addr,
  input wire logic [TWU_SFR_DW-1:0] wdata,
  input wire logic [TWU_SFR_DW-1:0] rdata,
  input wire logic [TWU_IRQ_SOURCES-1:0] i_irq_flags,
  input wire logic o_irq_request,
  input wire logic [7:0] o_watchdog_ctrl,
  input wire logic [7:0] o_brownout_ctrl,
  input wire logic o_window_open,
  input wire logic o_write_dropped
);
  logic key_wr; // Any write to the key register
  logic key2_ok; // Second key seen while the wait is running
  logic prot_wr; // Write to either protected register
  logic irq_exp; // Request expected from the enable copy
  logic [2:0] wait_d, wait_q; // Own copy of the wait counter
  logic [7:0] ie_d, ie_q; // Own copy of the enable register

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper state; clock enable is held high by the bench, so it is ignored here
  always_comb begin
    key_wr = wr && (addr == TWU_KEY_ADDR);
    key2_ok = key_wr && (wdata == TWU_KEY_SECOND) && (wait_q != 3'h0);
    prot_wr = wr && ((addr == TWU_WDOG_ADDR) || (addr == TWU_BOD_ADDR));
    irq_exp = ie_q[TWU_IE_GLOBAL_BIT] && (|(ie_q[6:0] & i_irq_flags));
    ie_d = (wr && (addr == TWU_IE_ADDR)) ? wdata : ie_q;
    if (key_wr && (wdata == TWU_KEY_FIRST)) begin
      wait_d = 3'(TWU_WAIT_CYCLES);
    end else if (key_wr) begin
      wait_d = 3'h0; // Any other key write abandons the wait
    end else if (wait_q != 3'h0) begin
      wait_d = wait_q - 3'h1;
    end else begin
      wait_d = wait_q;
    end
  end

  // Registers of the helper copies
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wait_q <= 3'h0;
      ie_q <= TWU_IE_RESET;
    end else begin
      wait_q <= wait_d;
      ie_q <= ie_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_window_len: assert property (key2_ok |=> o_window_open [*4] ##1 !o_window_open)
    else $error("write window length wrong");
  chk_late_key: assert property (key_wr && wait_q == 3'h0 && !o_window_open |=> !o_window_open)
    else $error("window opened without a timely first key");
  chk_rose_cause: assert property ($rose(o_window_open) |-> $past(key2_ok))
    else $error("window opened with no accepted key pair");
  chk_drop_closed: assert property (prot_wr && !o_window_open |=>
    o_write_dropped && $stable(o_watchdog_ctrl) && $stable(o_brownout_ctrl))
    else $error("protected write outside window not dropped");
  chk_wdog_lands: assert property (wr && addr == TWU_WDOG_ADDR && o_window_open |=>
    o_watchdog_ctrl == $past(wdata) && !o_write_dropped)
    else $error("watchdog write inside window lost");
  chk_bod_lands: assert property (wr && addr == TWU_BOD_ADDR && o_window_open |=>
    o_brownout_ctrl == $past(wdata))
    else $error("brownout write inside window lost");
  chk_read_free: assert property (rd && addr == TWU_WDOG_ADDR |=> rdata == $past(o_watchdog_ctrl))
    else $error("protected read gated");
  chk_key_zero: assert property (rd && addr == TWU_KEY_ADDR |=> rdata == 8'h00)
    else $error("key register readable");
  chk_irq_gate: assert property (1'b1 |=> o_irq_request == $past(irq_exp))
    else $error("interrupt request wrong");
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Both ends joined; software side driven over Avalon-MM
module tb_top;
  import twu_pkg::*;
  logic i_clk, i_reset;
  logic [TWU_AV_AW-1:0] av_addr; // Avalon request signals
  logic av_rd, av_wr;
  logic [31:0] av_wdata, av_rdata, rd_word;
  logic av_wait, irq, win_open, dropped;
  logic [TWU_IRQ_SOURCES-1:0] irq_flags; // Interrupt sources, held as levels
  logic [7:0] wdog, bod, rval;
  int fails, n_tests;

  twu_sfr_if twu_sfr_if_i ();
  twu_core twu_core_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
    .i_av_address(av_addr), .i_av_read(av_rd), .i_av_write(av_wr),
    .i_av_writedata(av_wdata), .o_av_readdata(av_rdata), .o_av_waitrequest(av_wait),
    .sfr(twu_sfr_if_i.core));
  twu_gate twu_gate_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
    .sfr(twu_sfr_if_i.gate), .i_irq_flags(irq_flags), .o_irq_request(irq),
    .o_watchdog_ctrl(wdog), .o_brownout_ctrl(bod), .o_window_open(win_open),
    .o_write_dropped(dropped));
  twu_asserts twu_asserts_i (.i_clk(i_clk), .i_reset(i_reset), .wr(twu_sfr_if_i.wr),
    .rd(twu_sfr_if_i.rd), .addr(twu_sfr_if_i.addr), .wdata(twu_sfr_if_i.wdata),
    .rdata(twu_sfr_if_i.rdata), .i_irq_flags(irq_flags), .o_irq_request(irq),
    .o_watchdog_ctrl(wdog), .o_brownout_ctrl(bod), .o_window_open(win_open),
    .o_write_dropped(dropped));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One Avalon request, held until the rising edge that samples waitrequest low;
  // left standing so that a following request can go out back to back
  task automatic av_req(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    av_addr <= a;
    av_rd <= is_rd;
    av_wr <= !is_rd;
    av_wdata <= d;
    @(posedge i_clk);
    while (av_wait !== 1'b0) begin
      n++;
      if (n > 100) begin
        fails++;
        end_sim();
      end
      @(posedge i_clk);
    end
    rd_word = av_rdata;
  endtask

  // One transfer, then release and one idle edge so strobes never toggle in one step
  task automatic av_xfer(input logic is_rd, input logic [3:0] a, input logic [31:0] d);
    av_req(is_rd, a, d);
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Poll status until the sequencer is idle
  task automatic wait_idle();
    for (int n = 0; n < 50; n++) begin
      av_xfer(1'b1, TWU_AV_STAT_OFS, 32'h0);
      if (rd_word[TWU_AV_BUSY_BIT] === 1'b0) return;
    end
    fails++;
    end_sim();
  endtask

  task automatic sfr_wr(input logic [3:0] ofs, input logic [7:0] a, input logic [7:0] d);
    av_xfer(1'b0, ofs, {16'h0, a, d});
    wait_idle();
  endtask

  task automatic sfr_rd(input logic [7:0] a);
    av_xfer(1'b0, TWU_AV_READ_OFS, {16'h0, a, 8'h00});
    wait_idle();
    rval = rd_word[7:0];
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Hang guard for the whole run
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    end_sim();
  end

  initial begin
    i_reset = 1'b1;
    av_addr = 4'h0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    irq_flags = 7'h00;
    fails = 0;
    n_tests = 0;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    sfr_rd(TWU_KEY_ADDR);
    check("key read", rval, TWU_KEY_RESET);
    sfr_rd(TWU_WDOG_ADDR);
    check("wdog reset", rval, TWU_WDOG_RESET);
    sfr_wr(TWU_AV_WRITE_OFS, TWU_WDOG_ADDR, 8'h5a);
    check("wdog closed", wdog, TWU_WDOG_RESET);
    $display("test reset and closed gate done");
    sfr_wr(TWU_AV_PROT_OFS, TWU_WDOG_ADDR, 8'h3c);
    sfr_rd(TWU_WDOG_ADDR);
    check("wdog unlocked", rval, 8'h3c);
    sfr_wr(TWU_AV_PROT_OFS, TWU_BOD_ADDR, 8'hc3);
    check("bod unlocked", bod, 8'hc3);
    // The window must have closed by itself before this plain write
    sfr_wr(TWU_AV_WRITE_OFS, TWU_BOD_ADDR, 8'h11);
    check("bod after window", bod, 8'hc3);
    $display("test unlock done");
    // Keys far apart: polling between them takes well over the wait
    sfr_wr(TWU_AV_WRITE_OFS, TWU_KEY_ADDR, TWU_KEY_FIRST);
    sfr_wr(TWU_AV_WRITE_OFS, TWU_KEY_ADDR, TWU_KEY_SECOND);
    sfr_wr(TWU_AV_WRITE_OFS, TWU_WDOG_ADDR, 8'h77);
    check("wdog late key", wdog, 8'h3c);
    // Keys in consecutive cycles: without the stray value the pair would be in time
    av_req(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_FIRST});
    av_req(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, 8'h12});
    av_xfer(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_SECOND});
    sfr_wr(TWU_AV_WRITE_OFS, TWU_WDOG_ADDR, 8'h66);
    check("wdog wrong key", wdog, 8'h3c);
    av_xfer(1'b0, 4'h2, 32'h0000_d899);
    // A wrongly decoded protected write would land two edges after the idle edge
    repeat (2) @(posedge i_clk);
    check("wdog unmapped", wdog, 8'h3c);
    // Second key exactly three cycles after the first still opens the window
    av_xfer(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_FIRST});
    @(posedge i_clk);
    av_xfer(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_SECOND});
    sfr_wr(TWU_AV_WRITE_OFS, TWU_WDOG_ADDR, 8'h21);
    check("wdog third cycle", wdog, 8'h21);
    // Status polling outlasts the window, so this second write comes too late
    sfr_wr(TWU_AV_WRITE_OFS, TWU_BOD_ADDR, 8'h44);
    check("bod second late", bod, 8'hc3);
    // Second key four cycles after the first is refused
    av_xfer(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_FIRST});
    repeat (2) @(posedge i_clk);
    av_xfer(1'b0, TWU_AV_WRITE_OFS, {16'h0, TWU_KEY_ADDR, TWU_KEY_SECOND});
    sfr_wr(TWU_AV_WRITE_OFS, TWU_WDOG_ADDR, 8'h22);
    check("wdog fourth cycle", wdog, 8'h21);
    $display("test refused keys done");
    irq_flags <= 7'h01;
    sfr_wr(TWU_AV_WRITE_OFS, TWU_IE_ADDR, 8'h01);
    check("irq global off", {7'h0, irq}, 8'h00);
    sfr_wr(TWU_AV_WRITE_OFS, TWU_IE_ADDR, 8'h81);
    check("irq pending served", {7'h0, irq}, 8'h01);
    irq_flags <= 7'h00;
    repeat (2) @(posedge i_clk);
    check("irq cleared", {7'h0, irq}, 8'h00);
    $display("test interrupt gate done");
    end_sim();
  end
endmodule
`default_nettype wire
